/* shared/rtcreg_pkg.sv */
// Register map, field layout and mode codes of the RTC counter/calendar registers.
// Assumes a 32-bit APB slave; every register sits at byte address four times its index.
`default_nettype none

package rtcreg_pkg;

	// Register indices; byte address is index times four
	localparam logic [7:0] RTCREG_IDX_CTRL = 8'h00;
	localparam logic [7:0] RTCREG_IDX_FLAG = 8'h08;
	localparam logic [7:0] RTCREG_IDX_STATUS = 8'h0A;
	localparam logic [7:0] RTCREG_IDX_DEBUG = 8'h0B;
	localparam logic [7:0] RTCREG_IDX_TRIM = 8'h0C;
	localparam logic [7:0] RTCREG_IDX_COUNT = 8'h10;
	localparam logic [7:0] RTCREG_IDX_TOP = 8'h14;

	// Control register layout
	localparam int RTCREG_CTRL_SWRST_BIT = 0;
	localparam int RTCREG_CTRL_ENABLE_BIT = 1;
	localparam int RTCREG_CTRL_MODE_LSB = 2;
	localparam int RTCREG_CTRL_12H_BIT = 6;

	// Single-bit fields of status, flag, debug and trim registers, plus trim magnitude and short-count widths
	localparam int RTCREG_STATUS_BUSY_BIT = 7;
	localparam int RTCREG_FLAG_DONE_BIT = 6;
	localparam int RTCREG_DEBUG_RUN_BIT = 0;
	localparam int RTCREG_TRIM_SIGN_BIT = 7;
	localparam int RTCREG_TRIM_MAG_W = 7;
	localparam int RTCREG_SHORT_W = 16;

	// Calendar word layout
	localparam int RTCREG_YEAR_LSB = 26;
	localparam int RTCREG_MONTH_LSB = 22;
	localparam int RTCREG_DAY_LSB = 17;
	localparam int RTCREG_HOUR_LSB = 12;
	localparam int RTCREG_MIN_LSB = 6;
	localparam int RTCREG_SEC_LSB = 0;

	// Calendar limits
	localparam logic [5:0] RTCREG_SEC_MAX = 6'h3B;
	localparam logic [4:0] RTCREG_HOUR24_MAX = 5'h17;
	localparam logic [3:0] RTCREG_HOUR12_MAX = 4'hC;
	localparam logic [3:0] RTCREG_HOUR12_LAST = 4'hB;
	localparam logic [3:0] RTCREG_MONTH_FIRST = 4'h1;
	localparam logic [3:0] RTCREG_MONTH_FEB = 4'h2;
	localparam logic [3:0] RTCREG_MONTH_MAX = 4'hC;
	localparam logic [4:0] RTCREG_DAY_FIRST = 5'h01;

	// Reset values
	localparam logic [31:0] RTCREG_WORD_RST = 32'h0000_0000;
	localparam logic [7:0] RTCREG_BYTE_RST = 8'h00;
	localparam logic [15:0] RTCREG_SHORT_RST = 16'h0000;

	typedef enum logic [1:0] {
		RTCREG_MODE_COUNT32 = 2'b00,
		RTCREG_MODE_COUNT16 = 2'b01,
		RTCREG_MODE_CALENDAR = 2'b10,
		RTCREG_MODE_RESERVED = 2'b11
	} rtcreg_mode_t;

	typedef enum logic {
		RTCREG_SYNC_IDLE = 1'b0,
		RTCREG_SYNC_BUSY = 1'b1
	} rtcreg_sync_state_t;

endpackage : rtcreg_pkg

`default_nettype wire

/* core/rtcreg_sync.sv */
// Tracks one register synchronisation from the bus side into the counter side.
// Assumes start is a one-cycle pulse from the register file; restarts extend the busy time.
`default_nettype none

module rtcreg_sync #(
	parameter int SYNC_CYCLES = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic quiet,
	output logic busy,
	output logic apply,
	output logic done
);
	import rtcreg_pkg::*;

	localparam int CW = (SYNC_CYCLES > 1) ? $clog2(SYNC_CYCLES) : 1;
	localparam logic [CW-1:0] LAST = CW'(SYNC_CYCLES - 1);

	rtcreg_sync_state_t state_reg;
	logic [CW-1:0] cnt_reg;
	logic quiet_reg;

	initial begin
		if (SYNC_CYCLES < 1) $error("SYNC_CYCLES must be at least one");
	end

	// Busy window; a new start restarts the window so the last write is applied
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= RTCREG_SYNC_IDLE;
			cnt_reg <= '0;
		end else begin
			case (state_reg)
				RTCREG_SYNC_IDLE: begin
					if (start) begin
						state_reg <= RTCREG_SYNC_BUSY;
						cnt_reg <= LAST;
					end
				end
				RTCREG_SYNC_BUSY: begin
					if (start) begin
						cnt_reg <= LAST;
					end else if (cnt_reg == '0) begin
						state_reg <= RTCREG_SYNC_IDLE;
					end else begin
						cnt_reg <= cnt_reg - CW'(1);
					end
				end
				default: state_reg <= RTCREG_SYNC_IDLE;
			endcase
		end
	end

	// Enable or reset causes are remembered until the window closes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_reg <= 1'b0;
		end else if (start) begin
			quiet_reg <= quiet | (quiet_reg & (state_reg == RTCREG_SYNC_BUSY));
		end
	end

	// Apply and done pulse on the falling edge of busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apply <= 1'b0;
			done <= 1'b0;
		end else begin
			apply <= (state_reg == RTCREG_SYNC_BUSY) && !start && (cnt_reg == '0);
			done <= (state_reg == RTCREG_SYNC_BUSY) && !start && (cnt_reg == '0)
				&& !quiet_reg;
		end
	end

	assign busy = (state_reg == RTCREG_SYNC_BUSY);

endmodule : rtcreg_sync

`default_nettype wire

/* core/rtcreg_calendar.sv */
// Next calendar word after one second, in 24-hour or 12-hour form.
// Purely combinational; assumes the incoming word holds legal field values.
`default_nettype none

module rtcreg_calendar (
	input wire logic [31:0] now,
	input wire logic twelve_hour_select,
	output logic [31:0] next
);
	import rtcreg_pkg::*;

	// Last day of a month; leap when the two low year bits are zero
	function automatic logic [4:0] last_day(input logic [3:0] month, input logic [5:0] year);
		logic [4:0] d;
		d = 5'h1F;
		if (month == RTCREG_MONTH_FEB) begin
			d = (year[1:0] == 2'b00) ? 5'h1D : 5'h1C;
		end else if (month == 4'h4 || month == 4'h6 || month == 4'h9 || month == 4'hB) begin
			d = 5'h1E;
		end
		return d;
	endfunction : last_day

	logic [5:0] year, minute, second;
	logic [3:0] month;
	logic [4:0] day, hour;
	logic day_roll;

	always_comb begin
		year = now[RTCREG_YEAR_LSB +: 6];
		month = now[RTCREG_MONTH_LSB +: 4];
		day = now[RTCREG_DAY_LSB +: 5];
		hour = now[RTCREG_HOUR_LSB +: 5];
		minute = now[RTCREG_MIN_LSB +: 6];
		second = now[RTCREG_SEC_LSB +: 6];
		day_roll = 1'b0;
		// Seconds and minutes each run 0 to 59
		if (second >= RTCREG_SEC_MAX) begin
			second = 6'h00;
			if (minute >= RTCREG_SEC_MAX) begin
				minute = 6'h00;
				if (twelve_hour_select) begin
					// 11 PM rolls to 12 AM of the next day; 11 AM to 12 PM
					if (hour[3:0] == RTCREG_HOUR12_LAST) begin
						hour = {~hour[4], RTCREG_HOUR12_MAX};
						day_roll = hour[4] == 1'b0;
					end else if (hour[3:0] >= RTCREG_HOUR12_MAX) begin
						hour = {hour[4], 4'h1};
					end else begin
						hour = {hour[4], hour[3:0] + 4'h1};
					end
				end else if (hour >= RTCREG_HOUR24_MAX) begin
					hour = 5'h00;
					day_roll = 1'b1;
				end else begin
					hour = hour + 5'h01;
				end
			end else begin
				minute = minute + 6'h01;
			end
		end else begin
			second = second + 6'h01;
		end
		// Day, month and year carries
		if (day_roll) begin
			if (day >= last_day(month, year)) begin
				day = RTCREG_DAY_FIRST;
				if (month >= RTCREG_MONTH_MAX) begin
					month = RTCREG_MONTH_FIRST;
					year = year + 6'h01;
				end else begin
					month = month + 4'h1;
				end
			end else begin
				day = day + 5'h01;
			end
		end
		next = {year, month, day, hour, minute, second};
	end

endmodule : rtcreg_calendar

`default_nettype wire

/* core/rtcreg_top.sv */
// RTC counter, calendar, frequency trim and sync-busy registers behind an APB slave.
// Assumes a single pclk; the counter side is a prescaled tick inside the same clock.
//
// Behaviour
// - Busy bit seven sets when sync starts
// - Busy bit clears when sync finishes
// - Reserved bits read zero; software writes zero
// - Run-in-debug bit survives software reset
// - Run-in-debug zero halts counting in debug
// - Run-in-debug one keeps counting in debug
// - Trim bit seven: zero faster, one slower
// - Zero trim magnitude leaves prescaler unchanged
// - Trim magnitude shifts rate proportionally
// - 32-bit mode: full count at 0x10
// - 16-bit mode: 16-bit count at 0x10
// - 16-bit mode: top value at 0x14
// - Year bits 31:26, leap if low bits zero
// - Month bits 25:22 count 1 to 12
// - Day bits 21:17 roll per month length
// - 24-hour form counts hours 0 to 23
// - 12-hour form: 1-12 plus PM bit
// - Minutes and seconds count 0 to 59
// - Done flag on busy fall, unless enable/reset
//
// Design decision made here: the APB slave port.
`default_nettype none

module rtcreg_top #(
	parameter int ADDR_W = 12,
	parameter int PRESCALE = 32,
	parameter int SYNC_CYCLES = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic debug_halt,
	output logic sync_in_progress,
	output logic sync_done_flag
);
	import rtcreg_pkg::*;

	localparam int PW = $clog2(PRESCALE + 2);
	localparam logic [PW-1:0] PRESC_LAST = PW'(PRESCALE - 1);

	initial begin
		if (ADDR_W < 7) $error("ADDR_W too small for the register map");
		if (PRESCALE < 4) $error("PRESCALE must be at least four");
	end

	// Address match for a register index, word aligned
	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		return addr == ADDR_W'({idx, 2'b00});
	endfunction : hit

	// Applied (counter side) state
	logic enable_reg;
	rtcreg_mode_t mode_reg;
	logic twelve_hour_select;
	logic [7:0] rate_trim;
	logic [31:0] count_reg;
	logic [15:0] counter_top;
	logic run_in_debug;
	logic flag_reg;

	// Values written by software, waiting for the sync window to close
	logic [31:0] pend_data_reg [4];
	logic [3:0] pend_mask_reg;
	localparam int P_CTRL = 0;
	localparam int P_TRIM = 1;
	localparam int P_COUNT = 2;
	localparam int P_TOP = 3;

	// Prescaler and correction state
	logic [PW-1:0] presc_reg;
	logic [RTCREG_TRIM_MAG_W-1:0] phase_reg;
	logic tick;
	logic running;
	logic [PW-1:0] presc_limit;

	// Bus-side decode
	logic wr_access, setup;
	logic [3:0] wr_hit;
	logic sync_start, sync_quiet, sync_apply, sync_done;
	logic swrst_apply;
	logic [31:0] cal_next;
	logic [31:0] rd_data;
	logic rd_err;
	logic ctrl_enable_new;

	assign setup = psel && !penable;
	assign wr_access = psel && penable && pready && pwrite;

	// Which synchronised registers this write touches
	always_comb begin
		wr_hit = 4'h0;
		if (hit(paddr, RTCREG_IDX_CTRL)) begin
			wr_hit[P_CTRL] = 1'b1;
		end else if (hit(paddr, RTCREG_IDX_TRIM)) begin
			wr_hit[P_TRIM] = 1'b1;
		end else if (hit(paddr, RTCREG_IDX_COUNT)) begin
			wr_hit[P_COUNT] = 1'b1;
		end else if (hit(paddr, RTCREG_IDX_TOP)) begin
			wr_hit[P_TOP] = 1'b1;
		end
	end

	// Enable changes and software reset do not raise the done flag
	assign ctrl_enable_new = pwdata[RTCREG_CTRL_ENABLE_BIT];
	assign sync_start = wr_access && (wr_hit != 4'h0);
	assign sync_quiet = wr_hit[P_CTRL] && (pwdata[RTCREG_CTRL_SWRST_BIT]
		|| (ctrl_enable_new != enable_reg));

	rtcreg_sync #(
		.SYNC_CYCLES(SYNC_CYCLES)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.start(sync_start),
		.quiet(sync_quiet),
		.busy(sync_in_progress),
		.apply(sync_apply),
		.done(sync_done)
	);

	rtcreg_calendar u_calendar (
		.now(count_reg),
		.twelve_hour_select(twelve_hour_select),
		.next(cal_next)
	);

	// Pending write values; each write overrides the earlier one of its register
	generate
		for (genvar i = 0; i < 4; i++) begin : g_pend
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pend_data_reg[i] <= RTCREG_WORD_RST;
					pend_mask_reg[i] <= 1'b0;
				end else if (wr_access && wr_hit[i]) begin
					pend_data_reg[i] <= pwdata;
					pend_mask_reg[i] <= 1'b1;
				end else if (sync_apply) begin
					pend_mask_reg[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign swrst_apply = sync_apply && pend_mask_reg[P_CTRL]
		&& pend_data_reg[P_CTRL][RTCREG_CTRL_SWRST_BIT];

	// Control fields land when the window closes; reset returns them to zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= 1'b0;
			mode_reg <= RTCREG_MODE_COUNT32;
			twelve_hour_select <= 1'b0;
		end else if (swrst_apply) begin
			enable_reg <= 1'b0;
			mode_reg <= RTCREG_MODE_COUNT32;
			twelve_hour_select <= 1'b0;
		end else if (sync_apply && pend_mask_reg[P_CTRL]) begin
			enable_reg <= pend_data_reg[P_CTRL][RTCREG_CTRL_ENABLE_BIT];
			mode_reg <= rtcreg_mode_t'(pend_data_reg[P_CTRL][RTCREG_CTRL_MODE_LSB +: 2]);
			twelve_hour_select <= pend_data_reg[P_CTRL][RTCREG_CTRL_12H_BIT];
		end
	end

	// Debug control is not synchronised and ignores software reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_in_debug <= 1'b0;
		end else if (wr_access && hit(paddr, RTCREG_IDX_DEBUG)) begin
			run_in_debug <= pwdata[RTCREG_DEBUG_RUN_BIT];
		end
	end

	// Frequency trim and period register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_trim <= RTCREG_BYTE_RST;
			counter_top <= RTCREG_SHORT_RST;
		end else if (swrst_apply) begin
			rate_trim <= RTCREG_BYTE_RST;
			counter_top <= RTCREG_SHORT_RST;
		end else if (sync_apply) begin
			if (pend_mask_reg[P_TRIM]) rate_trim <= pend_data_reg[P_TRIM][7:0];
			if (pend_mask_reg[P_TOP]) counter_top <= pend_data_reg[P_TOP][15:0];
		end
	end

	// Counting stops while halted in debug unless run-in-debug is set
	assign running = enable_reg && (mode_reg != RTCREG_MODE_RESERVED)
		&& !(debug_halt && !run_in_debug);

	// Corrected ticks are the first trim-magnitude ticks of each window of 128 ticks
	always_comb begin
		presc_limit = PRESC_LAST;
		if (rate_trim[RTCREG_TRIM_MAG_W-1:0] != '0
				&& phase_reg < rate_trim[RTCREG_TRIM_MAG_W-1:0]) begin
			if (rate_trim[RTCREG_TRIM_SIGN_BIT]) begin
				presc_limit = PRESC_LAST + PW'(1);
			end else begin
				presc_limit = PRESC_LAST - PW'(1);
			end
		end
	end

	assign tick = running && (presc_reg >= presc_limit);

	// Prescaler and correction phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_reg <= '0;
			phase_reg <= '0;
		end else if (swrst_apply || (sync_apply && pend_mask_reg[P_COUNT])) begin
			presc_reg <= '0;
			phase_reg <= '0;
		end else if (tick) begin
			presc_reg <= '0;
			phase_reg <= phase_reg + RTCREG_TRIM_MAG_W'(1);
		end else if (running) begin
			presc_reg <= presc_reg + PW'(1);
		end
	end

	// Counter in its three forms
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= RTCREG_WORD_RST;
		end else if (swrst_apply) begin
			count_reg <= RTCREG_WORD_RST;
		end else if (sync_apply && pend_mask_reg[P_COUNT]) begin
			if (mode_reg == RTCREG_MODE_COUNT16) begin
				count_reg <= {16'h0000, pend_data_reg[P_COUNT][15:0]};
			end else begin
				count_reg <= pend_data_reg[P_COUNT];
			end
		end else if (tick) begin
			case (mode_reg)
				RTCREG_MODE_COUNT32: count_reg <= count_reg + 32'h0000_0001;
				RTCREG_MODE_COUNT16: begin
					if (count_reg[15:0] >= counter_top) begin
						count_reg <= RTCREG_WORD_RST;
					end else begin
						count_reg <= {16'h0000, count_reg[15:0] + 16'h0001};
					end
				end
				RTCREG_MODE_CALENDAR: count_reg <= cal_next;
				default: count_reg <= count_reg;
			endcase
		end
	end

	// Done flag; a new done event wins over a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg <= 1'b0;
		end else if (sync_done) begin
			flag_reg <= 1'b1;
		end else if (swrst_apply) begin
			flag_reg <= 1'b0;
		end else if (wr_access && hit(paddr, RTCREG_IDX_FLAG)
				&& pwdata[RTCREG_FLAG_DONE_BIT]) begin
			flag_reg <= 1'b0;
		end
	end

	assign sync_done_flag = flag_reg;

	// Read mux; unused bits read zero
	always_comb begin
		rd_data = RTCREG_WORD_RST;
		rd_err = 1'b0;
		if (hit(paddr, RTCREG_IDX_CTRL)) begin
			rd_data[RTCREG_CTRL_ENABLE_BIT] = enable_reg;
			rd_data[RTCREG_CTRL_MODE_LSB +: 2] = mode_reg;
			rd_data[RTCREG_CTRL_12H_BIT] = twelve_hour_select;
		end else if (hit(paddr, RTCREG_IDX_FLAG)) begin
			rd_data[RTCREG_FLAG_DONE_BIT] = flag_reg;
		end else if (hit(paddr, RTCREG_IDX_STATUS)) begin
			rd_data[RTCREG_STATUS_BUSY_BIT] = sync_in_progress;
		end else if (hit(paddr, RTCREG_IDX_DEBUG)) begin
			rd_data[RTCREG_DEBUG_RUN_BIT] = run_in_debug;
		end else if (hit(paddr, RTCREG_IDX_TRIM)) begin
			rd_data[7:0] = rate_trim;
		end else if (hit(paddr, RTCREG_IDX_COUNT)) begin
			if (mode_reg == RTCREG_MODE_COUNT16) begin
				rd_data[RTCREG_SHORT_W-1:0] = count_reg[15:0];
			end else begin
				rd_data = count_reg;
			end
		end else if (hit(paddr, RTCREG_IDX_TOP)) begin
			rd_data[RTCREG_SHORT_W-1:0] = counter_top;
		end else begin
			rd_err = 1'b1;
		end
	end

	// One-wait-free answer: data is captured in setup so every output is a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= RTCREG_WORD_RST;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= pwrite ? RTCREG_WORD_RST : rd_data;
				pslverr <= rd_err;
			end else begin
				prdata <= RTCREG_WORD_RST;
				pslverr <= 1'b0;
			end
		end
	end

endmodule : rtcreg_top

`default_nettype wire

/* tb/rtcreg_monitor.sv */
// Concurrent checks on the APB answer and the sync outputs of the RTC register block.
// Assumes the package byte map (four times the index) and the single pclk domain.
`default_nettype none

module rtcreg_monitor
	import rtcreg_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int SYNC_CYCLES = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic debug_halt,
	input wire logic sync_in_progress,
	input wire logic sync_done_flag
);
	logic [ADDR_W-1:0] widx;
	logic mapped;
	logic rd_acc;
	logic sync_wr;
	logic [7:0] busy_cnt_reg;

	// Decode of the word index; low address bits ignored
	assign widx = paddr >> 2;
	// Unaligned addresses are refused by the slave, so they count as unmapped here
	assign mapped = (paddr[1:0] == 2'b00) && (widx inside {ADDR_W'(RTCREG_IDX_CTRL),
		ADDR_W'(RTCREG_IDX_FLAG), ADDR_W'(RTCREG_IDX_STATUS), ADDR_W'(RTCREG_IDX_DEBUG),
		ADDR_W'(RTCREG_IDX_TRIM), ADDR_W'(RTCREG_IDX_COUNT), ADDR_W'(RTCREG_IDX_TOP)});
	assign rd_acc = pready && !pwrite;
	assign sync_wr = psel && penable && pready && pwrite && (paddr[1:0] == 2'b00)
		&& (widx inside {ADDR_W'(RTCREG_IDX_CTRL), ADDR_W'(RTCREG_IDX_TRIM),
		ADDR_W'(RTCREG_IDX_COUNT), ADDR_W'(RTCREG_IDX_TOP)});

	// Busy cycles since the last synchronised write; a new write restarts the window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			busy_cnt_reg <= 8'h00;
		else if (sync_wr)
			busy_cnt_reg <= 8'h00;
		else if (sync_in_progress)
			busy_cnt_reg <= busy_cnt_reg + 8'h01;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence setup_s;
		psel && !penable;
	endsequence
	sequence sync_wr_s;
		sync_wr;
	endsequence

	ready_after_setup_a: assert property (setup_s |=> pready)
		else $error("pready missing after setup");
	ready_in_access_a: assert property (pready |->
		psel && penable && $past(psel) && !$past(penable))
		else $error("pready outside access phase");
	busy_on_write_a: assert property (sync_wr_s |=> sync_in_progress)
		else $error("busy not set by synchronised write");
	busy_holds_a: assert property (sync_in_progress
		&& busy_cnt_reg < SYNC_CYCLES - 1 |=> sync_in_progress)
		else $error("busy dropped early");
	busy_ends_a: assert property (sync_in_progress
		&& busy_cnt_reg == SYNC_CYCLES - 1 && !sync_wr |=> !sync_in_progress)
		else $error("busy held too long");
	busy_fall_count_a: assert property ($fell(sync_in_progress) |->
		$past(busy_cnt_reg) == SYNC_CYCLES - 1)
		else $error("busy window length wrong");
	done_after_fall_a: assert property ($rose(sync_done_flag) |->
		$past(sync_in_progress, 2) && !$past(sync_in_progress))
		else $error("done flag without busy fall");
	error_decode_a: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr wrong for address");
	status_reserved_a: assert property (rd_acc && widx == ADDR_W'(RTCREG_IDX_STATUS) |->
		prdata[31:8] == 24'h0 && prdata[6:0] == 7'h0)
		else $error("status reserved bits not zero");
	status_busy_a: assert property (rd_acc && widx == ADDR_W'(RTCREG_IDX_STATUS) |->
		prdata[7] == $past(sync_in_progress))
		else $error("status busy bit differs from output");
	debug_reserved_a: assert property (rd_acc && widx == ADDR_W'(RTCREG_IDX_DEBUG) |->
		prdata[31:1] == 31'h0)
		else $error("debug reserved bits not zero");
endmodule : rtcreg_monitor

bind rtcreg_top rtcreg_monitor #(.ADDR_W(ADDR_W), .SYNC_CYCLES(SYNC_CYCLES)) u_monitor (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.debug_halt(debug_halt), .sync_in_progress(sync_in_progress),
	.sync_done_flag(sync_done_flag));

`default_nettype wire

/* tb/rtc_counter_calendar_regs_bench.sv */
// Directed bench for the RTC counter, calendar, trim and sync-busy registers.
// Assumes one 250 MHz pclk and APB byte addresses of four times the package index.
`default_nettype none

module rtc_counter_calendar_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import rtcreg_pkg::*;

	localparam logic [11:0] A_CTRL = {2'b00, RTCREG_IDX_CTRL, 2'b00};
	localparam logic [11:0] A_FLAG = {2'b00, RTCREG_IDX_FLAG, 2'b00};
	localparam logic [11:0] A_STAT = {2'b00, RTCREG_IDX_STATUS, 2'b00};
	localparam logic [11:0] A_DBG = {2'b00, RTCREG_IDX_DEBUG, 2'b00};
	localparam logic [11:0] A_TRIM = {2'b00, RTCREG_IDX_TRIM, 2'b00};
	localparam logic [11:0] A_CNT = {2'b00, RTCREG_IDX_COUNT, 2'b00};
	localparam logic [11:0] A_TOP = {2'b00, RTCREG_IDX_TOP, 2'b00};

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic debug_halt = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sync_in_progress;
	logic sync_done_flag;
	logic [31:0] rv;
	logic ev;
	int miscompares = 0;
	int tests_run = 0;

	// Short prescale keeps calendar and rate runs brief
	rtcreg_top #(.ADDR_W(12), .PRESCALE(4), .SYNC_CYCLES(4)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.debug_halt(debug_halt), .sync_in_progress(sync_in_progress),
		.sync_done_flag(sync_done_flag));

	// 4 ns clock
	always #2 pclk = ~pclk;

	task automatic complete_run();
		if (miscompares == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) chk({31'h0, pready}, 32'h1);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rv, exp);
	endtask : rdchk

	// Write, then wait out the sync window under a bound
	task automatic wrs(input logic [11:0] a, input logic [31:0] d);
		int n;
		apb(1'b1, a, d);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (sync_in_progress !== 1'b0 && n < 40);
		if (sync_in_progress !== 1'b0) chk({31'h0, sync_in_progress}, 32'h0);
	endtask : wrs

	function automatic logic [31:0] cal(int y, int m, int d, int h, int mi, int s);
		return 32'((y << 26) | (m << 22) | (d << 17) | (h << 12) | (mi << 6) | s);
	endfunction : cal

	task automatic t_reset();
		rdchk(A_DBG, 32'h0);
		rdchk(A_TRIM, 32'h0);
		rdchk(A_CNT, 32'h0);
		rdchk(A_TOP, 32'h0);
		apb(1'b1, A_STAT, 32'hFFFF_FFFF);
		rdchk(A_STAT, 32'h0);
		apb(1'b1, A_DBG, 32'hFFFF_FFFF);
		rdchk(A_DBG, 32'h1);
		apb(1'b1, A_DBG, 32'h0);
		apb(1'b0, 12'h03C, 32'h0);
		chk({ev, rv[30:0]}, 32'h8000_0000);
	endtask : t_reset

	task automatic t_sync();
		apb(1'b1, A_TOP, 32'h7);
		rdchk(A_STAT, 32'h80);
		wrs(A_STAT, 32'h0);
		rdchk(A_STAT, 32'h0);
		chk({31'h0, sync_done_flag}, 32'h1);
		rdchk(A_TOP, 32'h7);
		rdchk(A_FLAG, 32'h40);
		apb(1'b1, A_FLAG, 32'h40);
		rdchk(A_FLAG, 32'h0);
	endtask : t_sync

	task automatic t_count16();
		logic [31:0] top_seen;
		logic [31:0] prev;
		logic wrapped;
		top_seen = 32'h0;
		prev = 32'h0;
		wrapped = 1'b0;
		wrs(A_CNT, 32'h5);
		wrs(A_CTRL, 32'h6);
		repeat (40) begin
			apb(1'b0, A_CNT, 32'h0);
			if (rv > top_seen)
				top_seen = rv;
			if (rv < prev)
				wrapped = 1'b1;
			prev = rv;
		end
		chk(top_seen, 32'h7);
		chk({31'h0, wrapped}, 32'h1);
	endtask : t_count16

	task automatic t_debug();
		logic [31:0] a;
		debug_halt <= 1'b1;
		apb(1'b1, A_DBG, 32'h0);
		apb(1'b0, A_CNT, 32'h0);
		a = rv;
		repeat (40) @(posedge pclk);
		rdchk(A_CNT, a);
		apb(1'b1, A_DBG, 32'h1);
		apb(1'b0, A_CNT, 32'h0);
		a = rv;
		repeat (40) @(posedge pclk);
		apb(1'b0, A_CNT, 32'h0);
		chk({31'h0, rv !== a}, 32'h1);
		debug_halt <= 1'b0;
		wrs(A_CTRL, 32'h1);
		rdchk(A_DBG, 32'h1);
		rdchk(A_TOP, 32'h0);
		chk({31'h0, sync_done_flag}, 32'h0);
		// Reserved mode code keeps the counter still even when enabled
		wrs(A_CTRL, 32'hE);
		rdchk(A_CTRL, 32'hE);
		apb(1'b0, A_CNT, 32'h0);
		a = rv;
		repeat (20) @(posedge pclk);
		rdchk(A_CNT, a);
		apb(1'b1, A_DBG, 32'h0);
	endtask : t_debug

	// Rate over about 303 cycles: nominal, fastest and slowest trim
	task automatic t_trim();
		logic [7:0] tv [3] = '{8'h00, 8'h7F, 8'hFF};
		int lo [3] = '{74, 99, 58};
		int hi [3] = '{77, 102, 62};
		logic [31:0] a;
		wrs(A_CTRL, 32'h2);
		for (int i = 0; i < 3; i++) begin
			wrs(A_TRIM, {24'h0, tv[i]});
			rdchk(A_TRIM, {24'h0, tv[i]});
			wrs(A_CNT, 32'hFFFF_FF00);
			apb(1'b0, A_CNT, 32'h0);
			a = rv;
			chk({16'h0, a[31:16]}, 32'h0000_FFFF);
			repeat (300) @(posedge pclk);
			apb(1'b0, A_CNT, 32'h0);
			chk({31'h0, (rv - a) >= lo[i] && (rv - a) <= hi[i]}, 32'h1);
		end
		wrs(A_TRIM, 32'h0);
	endtask : t_trim

	// Load a time while halted, let exactly one second pass
	task automatic t_calendar();
		logic [31:0] cc [5];
		logic [31:0] st [5];
		logic [31:0] ex [5];
		int n;
		cc = '{32'h0A, 32'h0A, 32'h0A, 32'h4A, 32'h4A};
		st = '{cal(4, 2, 28, 23, 59, 59), cal(5, 2, 28, 23, 59, 59), cal(5, 4, 30, 23, 59, 59),
			cal(1, 12, 31, 'h1B, 59, 59), cal(1, 6, 10, 'h0B, 59, 59)};
		ex = '{cal(4, 2, 29, 0, 0, 0), cal(5, 3, 1, 0, 0, 0), cal(5, 5, 1, 0, 0, 0),
			cal(2, 1, 1, 'h0C, 0, 0), cal(1, 6, 10, 'h1C, 0, 0)};
		for (int i = 0; i < 5; i++) begin
			debug_halt <= 1'b1;
			wrs(A_CTRL, cc[i]);
			wrs(A_CNT, st[i]);
			rdchk(A_CNT, st[i]);
			debug_halt <= 1'b0;
			n = 0;
			do begin
				apb(1'b0, A_CNT, 32'h0);
				n++;
			end while (rv === st[i] && n < 30);
			chk(rv, ex[i]);
		end
	endtask : t_calendar

	// Main sequence after 20 cycles of reset
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_sync();
		t_count16();
		t_debug();
		t_trim();
		t_calendar();
		complete_run();
	end

	// Watchdog; the run needs about 1500 cycles
	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		complete_run();
	end
endmodule : rtc_counter_calendar_regs_bench

`default_nettype wire
